/* logic/dcs_defines.vh */
// constants for the drive command source controller
// assumes a 20 MHz clock and a half-duplex rs485 transceiver outside
// Notes on behaviour
// - speed reference follows frequency source setting
// - frequency source defaults to keypad
// - run command follows run source setting
// - run source defaults to keypad
// - reverse inhibit set refuses reverse requests
// - stop uses stop-mode setting, default decelerate
// - default keypad run ramps zero to 5 Hz
// - link defaults node 1, 9600, 8N1
// - link carries modbus rtu frames
// - request frames end in crc16
// - reference word at 0x2502, limit 40000
// - command bit0 forward, bit1 reverse
// - command 0x0003 runs reverse
// - command 0x0000 stops drive
// - display unit setting picks display format
// - first analog is master, second auxiliary
// - second analog type 0 volts, 1 current, default 1
`ifndef DCS_DEFINES_VH
`define DCS_DEFINES_VH
`define DCS_CLK_HZ 20000000
`define DCS_BAUD 9600
`define DCS_BIT_CYC (`DCS_CLK_HZ / `DCS_BAUD)
`define DCS_GAP_CYC (`DCS_BIT_CYC * 35 / 10)
`define DCS_NODE_DEF 8'h01
`define DCS_REG_CMD 16'h2501
`define DCS_REG_REF 16'h2502
`define DCS_FN_WRITE1 8'h06
`define DCS_FN_READ 8'h03
`define DCS_REF_MAX 16'h9c40
`define DCS_KEY_REF_DEF 16'h01f4
`define DCS_FSRC_KEYPAD 3'h0
`define DCS_FSRC_ANALOG 3'h1
`define DCS_FSRC_UPDN 3'h2
`define DCS_FSRC_COMM 3'h3
`define DCS_FSRC_PULSE 3'h4
`define DCS_FSRC_PID 3'h5
`define DCS_RSRC_KEYPAD 2'h0
`define DCS_RSRC_TERM 2'h1
`define DCS_RSRC_COMM 2'h2
`define DCS_RSRC_PLC 2'h3
`define DCS_STOP_DECEL 1'b0
`define DCS_AI2_CURRENT 1'b1
`define DCS_DISP_HZ 2'h0
`define DCS_DISP_PCT 2'h1
`define DCS_DISP_RPM 2'h2
`define DCS_DISP_CUSTOM 2'h3
`define DCS_RAMP_STEP 16'h0001
`endif

/* logic/dcs_uart_rx.v */
// serial byte receiver, 8 data bits, no parity, one stop bit
// assumes rx pin already passed through a two-stage synchroniser
`timescale 1ns/1ps
module dcs_uart_rx (
  input wire clk,
  input wire rst_n,
  input wire rx_sync,
  output reg [7:0] data_reg,
  output reg valid_reg,
  output reg idle_gap_reg
);
`include "dcs_defines.vh"
localparam ST_IDLE = 3'b001;
localparam ST_DATA = 3'b010;
localparam ST_STOP = 3'b100;
reg [2:0] state_reg;
reg [15:0] cnt_reg;
reg [2:0] bit_reg;
reg [15:0] gap_reg;
always @(posedge clk)
begin
  if (!rst_n)
  begin
    state_reg <= ST_IDLE;
    cnt_reg <= 16'h0000;
    bit_reg <= 3'h0;
    data_reg <= 8'h00;
    valid_reg <= 1'b0;
    gap_reg <= 16'h0000;
    idle_gap_reg <= 1'b1;
  end
  else
  begin
    valid_reg <= 1'b0;
    // silence of 3.5 bit times delimits an rtu frame
    if (state_reg == ST_IDLE && rx_sync)
    begin
      if (gap_reg >= `DCS_GAP_CYC)
        idle_gap_reg <= 1'b1;
      else
        gap_reg <= gap_reg + 16'h0001;
    end
    else
    begin
      gap_reg <= 16'h0000;
      idle_gap_reg <= 1'b0;
    end
    case (state_reg)
      ST_IDLE:
      begin
        if (!rx_sync)
        begin
          if (cnt_reg == `DCS_BIT_CYC / 2)
          begin
            cnt_reg <= 16'h0000;
            bit_reg <= 3'h0;
            state_reg <= ST_DATA;
          end
          else
            cnt_reg <= cnt_reg + 16'h0001;
        end
        else
          cnt_reg <= 16'h0000;
      end
      ST_DATA:
      begin
        if (cnt_reg == `DCS_BIT_CYC - 1)
        begin
          cnt_reg <= 16'h0000;
          data_reg <= {rx_sync, data_reg[7:1]};
          bit_reg <= bit_reg + 3'h1;
          if (bit_reg == 3'h7)
            state_reg <= ST_STOP;
        end
        else
          cnt_reg <= cnt_reg + 16'h0001;
      end
      ST_STOP:
      begin
        if (cnt_reg == `DCS_BIT_CYC - 1)
        begin
          cnt_reg <= 16'h0000;
          valid_reg <= rx_sync;
          state_reg <= ST_IDLE;
        end
        else
          cnt_reg <= cnt_reg + 16'h0001;
      end
      default:
        state_reg <= ST_IDLE;
    endcase
  end
end
endmodule

/* logic/dcs_top.v */
// drive command source controller: modbus rtu slave, source selection, ramp
// assumes rs485 transceiver outside; keys and terminals are raw pins
`timescale 1ns/1ps
module dcs_top (
  input wire clk,
  input wire rst_n,
  input wire rs485_rx,
  input wire [2:0] freq_source,
  input wire [1:0] run_source,
  input wire reverse_inhibit,
  input wire stop_mode,
  input wire [15:0] display_unit,
  input wire [15:0] keypad_ref,
  input wire keypad_run_key,
  input wire keypad_stop_key,
  input wire direction_key,
  input wire term_fwd,
  input wire term_rev,
  input wire plc_fwd,
  input wire plc_rev,
  input wire [15:0] analog_in_one,
  input wire [15:0] analog_in_two,
  input wire input_type_switch,
  input wire [15:0] updn_ref,
  input wire [15:0] pulse_ref,
  input wire [15:0] pid_ref,
  output reg run_reg,
  output reg reverse_reg,
  output reg coast_stop_reg,
  output reg [15:0] out_freq_reg,
  output reg [15:0] target_ref_reg,
  output reg [15:0] aux_ref_reg,
  output reg ai2_is_current_reg,
  output reg [1:0] disp_fmt_reg,
  output reg [15:0] run_command_word_reg,
  output reg [15:0] speed_reference_word_reg,
  output reg frame_err_reg
);
`include "dcs_defines.vh"
// crc16 step for one byte, polynomial 0xa001 reflected
function [15:0] crc_byte;
  input [15:0] c;
  input [7:0] d;
  integer i;
  reg [15:0] t;
  begin
    t = c ^ {8'h00, d};
    for (i = 0; i < 8; i = i + 1)
      t = t[0] ? ((t >> 1) ^ 16'ha001) : (t >> 1);
    crc_byte = t;
  end
endfunction
localparam F_ADDR = 4'h0;
localparam F_FUNC = 4'h1;
localparam F_RH = 4'h2;
localparam F_RL = 4'h3;
localparam F_DH = 4'h4;
localparam F_DL = 4'h5;
localparam F_CL = 4'h6;
localparam F_CH = 4'h7;
localparam F_DONE = 4'h8;
// pin inputs pass two flip-flops
reg [1:0] rx_s_reg;
reg [1:0] run_s_reg;
reg [1:0] stop_s_reg;
reg [1:0] dir_s_reg;
reg [1:0] tf_s_reg;
reg [1:0] tr_s_reg;
reg [1:0] sw_s_reg;
always @(posedge clk)
begin
  if (!rst_n)
  begin
    rx_s_reg <= 2'b11;
    run_s_reg <= 2'b00;
    stop_s_reg <= 2'b00;
    dir_s_reg <= 2'b00;
    tf_s_reg <= 2'b00;
    tr_s_reg <= 2'b00;
    sw_s_reg <= 2'b00;
  end
  else
  begin
    rx_s_reg <= {rx_s_reg[0], rs485_rx};
    run_s_reg <= {run_s_reg[0], keypad_run_key};
    stop_s_reg <= {stop_s_reg[0], keypad_stop_key};
    dir_s_reg <= {dir_s_reg[0], direction_key};
    tf_s_reg <= {tf_s_reg[0], term_fwd};
    tr_s_reg <= {tr_s_reg[0], term_rev};
    sw_s_reg <= {sw_s_reg[0], input_type_switch};
  end
end
wire [7:0] rx_data;
wire rx_valid;
wire rx_gap;
dcs_uart_rx u_rx (
  .clk(clk),
  .rst_n(rst_n),
  .rx_sync(rx_s_reg[1]),
  .data_reg(rx_data),
  .valid_reg(rx_valid),
  .idle_gap_reg(rx_gap)
);
reg [3:0] fpos_reg;
reg [15:0] crc_reg;
reg [7:0] func_reg;
reg [15:0] addr_reg;
reg [15:0] data_reg;
reg addressed_reg;
reg wr_cmd_reg;
reg wr_ref_reg;
// rtu frame parser, write single register only
always @(posedge clk)
begin
  if (!rst_n)
  begin
    fpos_reg <= F_ADDR;
    crc_reg <= 16'hffff;
    func_reg <= 8'h00;
    addr_reg <= 16'h0000;
    data_reg <= 16'h0000;
    addressed_reg <= 1'b0;
    wr_cmd_reg <= 1'b0;
    wr_ref_reg <= 1'b0;
    frame_err_reg <= 1'b0;
  end
  else
  begin
    wr_cmd_reg <= 1'b0;
    wr_ref_reg <= 1'b0;
    if (rx_gap)
    begin
      fpos_reg <= F_ADDR;
      crc_reg <= 16'hffff;
    end
    else if (rx_valid)
    begin
      crc_reg <= crc_byte(crc_reg, rx_data);
      case (fpos_reg)
        F_ADDR:
        begin
          addressed_reg <= (rx_data == `DCS_NODE_DEF);
          fpos_reg <= F_FUNC;
        end
        F_FUNC:
        begin
          func_reg <= rx_data;
          fpos_reg <= F_RH;
        end
        F_RH:
        begin
          addr_reg[15:8] <= rx_data;
          fpos_reg <= F_RL;
        end
        F_RL:
        begin
          addr_reg[7:0] <= rx_data;
          fpos_reg <= F_DH;
        end
        F_DH:
        begin
          data_reg[15:8] <= rx_data;
          fpos_reg <= F_DL;
        end
        F_DL:
        begin
          data_reg[7:0] <= rx_data;
          fpos_reg <= F_CL;
        end
        F_CL:
        begin
          fpos_reg <= F_CH;
        end
        F_CH:
        begin
          fpos_reg <= F_DONE;
          // crc run over frame plus its crc leaves zero
          if (crc_byte(crc_reg, rx_data) != 16'h0000)
            frame_err_reg <= 1'b1;
          // only function 06 for this node acts
          else if (addressed_reg && func_reg == `DCS_FN_WRITE1)
          begin
            frame_err_reg <= 1'b0;
            wr_cmd_reg <= (addr_reg == `DCS_REG_CMD);
            wr_ref_reg <= (addr_reg == `DCS_REG_REF);
          end
        end
        F_DONE:
          fpos_reg <= F_DONE;
        default:
          fpos_reg <= F_ADDR;
      endcase
    end
  end
end
always @(posedge clk)
begin
  if (!rst_n)
  begin
    run_command_word_reg <= 16'h0000;
    speed_reference_word_reg <= 16'h0000;
  end
  else
  begin
    if (wr_cmd_reg)
      run_command_word_reg <= data_reg;
    if (wr_ref_reg && data_reg <= `DCS_REF_MAX)
      speed_reference_word_reg <= data_reg;
  end
end
// speed reference mux; code 0 is keypad
reg [15:0] src_ref;
always @*
begin
  case (freq_source)
    `DCS_FSRC_KEYPAD: src_ref = keypad_ref;
    `DCS_FSRC_ANALOG: src_ref = analog_in_one;
    `DCS_FSRC_UPDN: src_ref = updn_ref;
    // serial reference only under comm source
    `DCS_FSRC_COMM: src_ref = speed_reference_word_reg;
    `DCS_FSRC_PULSE: src_ref = pulse_ref;
    `DCS_FSRC_PID: src_ref = pid_ref;
    default: src_ref = 16'h0000;
  endcase
end
// run request mux; code 0 is keypad
reg want_fwd;
reg want_rev;
reg key_run_reg;
reg key_rev_reg;
reg dir_d_reg;
always @*
begin
  case (run_source)
    `DCS_RSRC_KEYPAD:
    begin
      want_fwd = key_run_reg && !key_rev_reg;
      want_rev = key_run_reg && key_rev_reg;
    end
    `DCS_RSRC_TERM:
    begin
      want_fwd = tf_s_reg[1] && !tr_s_reg[1];
      want_rev = tr_s_reg[1];
    end
    // bit0 forward, bit1 reverse; 0x0003 reverse; zero stops
    `DCS_RSRC_COMM:
    begin
      want_fwd = run_command_word_reg[0] && !run_command_word_reg[1];
      want_rev = run_command_word_reg[1];
    end
    `DCS_RSRC_PLC:
    begin
      want_fwd = plc_fwd && !plc_rev;
      want_rev = plc_rev;
    end
    default:
    begin
      want_fwd = 1'b0;
      want_rev = 1'b0;
    end
  endcase
end
// keypad run latches forward, direction key toggles
always @(posedge clk)
begin
  if (!rst_n)
  begin
    key_run_reg <= 1'b0;
    key_rev_reg <= 1'b0;
    dir_d_reg <= 1'b0;
  end
  else
  begin
    dir_d_reg <= dir_s_reg[1];
    if (stop_s_reg[1])
      key_run_reg <= 1'b0;
    else if (run_s_reg[1] && !key_run_reg)
    begin
      key_run_reg <= 1'b1;
      key_rev_reg <= 1'b0;
    end
    else if (dir_s_reg[1] && !dir_d_reg)
      key_rev_reg <= !key_rev_reg;
  end
end
// drive state, ramp and stop handling
reg [15:0] ramp_cnt_reg;
always @(posedge clk)
begin
  if (!rst_n)
  begin
    run_reg <= 1'b0;
    reverse_reg <= 1'b0;
    coast_stop_reg <= 1'b0;
    out_freq_reg <= 16'h0000;
    target_ref_reg <= 16'h0000;
    ramp_cnt_reg <= 16'h0000;
  end
  else
  begin
    target_ref_reg <= src_ref;
    ramp_cnt_reg <= ramp_cnt_reg + 16'h0001;
    if (want_rev && !reverse_inhibit)
    begin
      run_reg <= 1'b1;
      reverse_reg <= 1'b1;
      coast_stop_reg <= 1'b0;
    end
    else if (want_fwd)
    begin
      run_reg <= 1'b1;
      reverse_reg <= 1'b0;
      coast_stop_reg <= 1'b0;
    end
    else
    begin
      run_reg <= 1'b0;
      // stop mode picks decelerate or coast
      coast_stop_reg <= (stop_mode != `DCS_STOP_DECEL);
    end
    // output frequency ramps toward reference from zero
    if (!run_reg && stop_mode != `DCS_STOP_DECEL)
      out_freq_reg <= 16'h0000;
    else if (ramp_cnt_reg == 16'h0000)
    begin
      if (run_reg && out_freq_reg < target_ref_reg)
        out_freq_reg <= out_freq_reg + `DCS_RAMP_STEP;
      else if (!run_reg || out_freq_reg > target_ref_reg)
      begin
        if (out_freq_reg != 16'h0000)
          out_freq_reg <= out_freq_reg - `DCS_RAMP_STEP;
      end
    end
  end
end
// analog roles and display format
always @(posedge clk)
begin
  if (!rst_n)
  begin
    aux_ref_reg <= 16'h0000;
    ai2_is_current_reg <= `DCS_AI2_CURRENT;
    disp_fmt_reg <= `DCS_DISP_HZ;
  end
  else
  begin
    // second analog is the auxiliary reference
    aux_ref_reg <= analog_in_two;
    ai2_is_current_reg <= sw_s_reg[1];
    if (display_unit == 16'h0000)
      disp_fmt_reg <= `DCS_DISP_HZ;
    else if (display_unit == 16'h0001)
      disp_fmt_reg <= `DCS_DISP_PCT;
    else if (display_unit <= 16'h0026)
      disp_fmt_reg <= `DCS_DISP_RPM;
    else
      disp_fmt_reg <= `DCS_DISP_CUSTOM;
  end
end
endmodule

/* dv/dcs_props.sv */
// port checks for the command source controller
// assumes bound to dcs_top; one clock, sync active-low reset
`timescale 1ns/1ps
module dcs_props (
  input wire clk,
  input wire rst_n,
  input wire [2:0] freq_source,
  input wire [1:0] run_source,
  input wire reverse_inhibit,
  input wire stop_mode,
  input wire [15:0] display_unit,
  input wire [15:0] keypad_ref,
  input wire run_reg,
  input wire reverse_reg,
  input wire coast_stop_reg,
  input wire [15:0] out_freq_reg,
  input wire [15:0] target_ref_reg,
  input wire [1:0] disp_fmt_reg,
  input wire [15:0] run_command_word_reg,
  input wire [15:0] speed_reference_word_reg,
  input wire frame_err_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_REF_LIMIT: assert property (speed_reference_word_reg <= 16'h9c40)
    else $error("reference word above limit");
  AST_KEY_REF: assert property (freq_source == 3'h0 |=> target_ref_reg == $past(keypad_ref))
    else $error("keypad reference not selected");
  AST_COMM_REF: assert property (freq_source == 3'h3
    |=> target_ref_reg == $past(speed_reference_word_reg))
    else $error("serial reference not selected");
  AST_NO_REVERSE: assert property (reverse_inhibit [*3] |-> !$rose(reverse_reg))
    else $error("reverse while inhibited");
  AST_COAST_MODE: assert property ($rose(coast_stop_reg) |-> $past(stop_mode))
    else $error("coast without coast mode");
  // a slip in the ramp counter shows as a jump
  AST_RAMP_STEP: assert property (!coast_stop_reg && $changed(out_freq_reg) |->
    (out_freq_reg - $past(out_freq_reg) == 16'h0001 ||
    $past(out_freq_reg) - out_freq_reg == 16'h0001))
    else $error("ramp step not one");
  AST_CMD_REVERSE: assert property (run_source == 2'h2 && !reverse_inhibit &&
    $changed(run_command_word_reg) && run_command_word_reg == 16'h0003 |->
    ##[1:3] (run_reg && reverse_reg))
    else $error("reverse command ignored");
  AST_CMD_STOP: assert property (run_source == 2'h2 &&
    $changed(run_command_word_reg) && run_command_word_reg == 16'h0000 |-> ##[1:3] !run_reg)
    else $error("stop command ignored");
  AST_ERR_HOLDS: assert property ($rose(frame_err_reg) |->
    $stable(speed_reference_word_reg) && $stable(run_command_word_reg))
    else $error("bad frame changed a register");
  AST_DISP_RPM: assert property ((display_unit == 16'h0004) [*3] |-> disp_fmt_reg == 2'h2)
    else $error("display format not rpm");
  cover property ($rose(run_reg) && reverse_reg);
  cover property ($rose(frame_err_reg));
  cover property ($changed(speed_reference_word_reg));
endmodule

/* dv/dcs_mb_master.sv */
// modbus rtu master model driving the drive's serial input
// assumes a 50 ns clock; one write-single-register frame per call
`timescale 1ns/1ps
module dcs_mb_master (
  input wire clk,
  output reg tx
);
  initial tx = 1'b1;
  function [15:0] crc(input [47:0] p);
    integer i, b;
    begin
      crc = 16'hffff;
      for (i = 5; i >= 0; i = i - 1)
      begin
        crc = crc ^ {8'h00, p[i*8 +: 8]};
        for (b = 0; b < 8; b = b + 1)
          crc = crc[0] ? (crc >> 1) ^ 16'ha001 : crc >> 1;
      end
    end
  endfunction
  task send(input [47:0] p, input bad);
    reg [15:0] c;
    reg [63:0] f;
    integer i, b;
    begin
      c = crc(p) ^ {15'h0, bad};
      f = {p, c[7:0], c[15:8]};
      for (i = 7; i >= 0; i = i - 1)
        for (b = 0; b < 10; b = b + 1)
        begin
          tx = b == 0 ? 1'b0 : b == 9 ? 1'b1 : f[i*8 + b - 1];
          repeat (2083) @(negedge clk);
        end
      // idle past the 3.5 bit-time gap so the next frame is seen apart
      repeat (8000) @(negedge clk);
    end
  endtask
endmodule

/* dv/testbench.sv */
// self-checking bench for the command source controller
// assumes logic/ files compiled first; a master model feeds rs485_rx
`timescale 1ns/1ps
module testbench;
  reg clk, rst_n, reverse_inhibit, stop_mode, keypad_run_key, keypad_stop_key;
  reg direction_key, term_fwd, term_rev, plc_fwd, plc_rev, input_type_switch;
  reg [2:0] freq_source;
  reg [1:0] run_source;
  reg [15:0] display_unit, keypad_ref, analog_in_one, analog_in_two;
  reg [15:0] updn_ref, pulse_ref, pid_ref;
  wire rs485_rx, run_reg, reverse_reg, coast_stop_reg, ai2_is_current_reg, frame_err_reg;
  wire [1:0] disp_fmt_reg;
  wire [15:0] out_freq_reg, target_ref_reg, aux_ref_reg, run_command_word_reg;
  wire [15:0] speed_reference_word_reg;
  integer errors, num_checks, i;
  dcs_mb_master i_dcs_mb_master (.clk, .tx(rs485_rx));
  dcs_top i_dcs_top (.clk, .rst_n, .rs485_rx, .freq_source, .run_source, .reverse_inhibit,
    .stop_mode, .display_unit, .keypad_ref, .keypad_run_key, .keypad_stop_key,
    .direction_key, .term_fwd, .term_rev, .plc_fwd, .plc_rev, .analog_in_one,
    .analog_in_two, .input_type_switch, .updn_ref, .pulse_ref, .pid_ref, .run_reg,
    .reverse_reg, .coast_stop_reg, .out_freq_reg, .target_ref_reg, .aux_ref_reg,
    .ai2_is_current_reg, .disp_fmt_reg, .run_command_word_reg,
    .speed_reference_word_reg, .frame_err_reg);
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task chk(input [15:0] seen, input [15:0] exp, input string nm);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
        errors = errors + 1;
        $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // keys pass a two-stage synchroniser, so hold and settle a few cycles
  task key(input integer k);
    begin
      keypad_run_key = k == 0;
      keypad_stop_key = k == 1;
      direction_key = k == 2;
      repeat (5) @(negedge clk);
      {keypad_run_key, keypad_stop_key, direction_key} = 3'h0;
      repeat (10) @(negedge clk);
    end
  endtask
  initial
  begin
    #80000000;
    errors = errors + 1;
    finish_test;
  end
  initial
  begin
    rst_n = 1'b0;
    {reverse_inhibit, stop_mode, keypad_run_key, keypad_stop_key, direction_key} = 5'h00;
    {term_fwd, term_rev, plc_fwd, plc_rev, input_type_switch} = 5'h00;
    freq_source = 3'h0;
    run_source = 2'h0;
    display_unit = 16'h0000;
    keypad_ref = 16'h01f4;
    analog_in_one = 16'h0111;
    updn_ref = 16'h0222;
    pulse_ref = 16'h0444;
    pid_ref = 16'h0555;
    analog_in_two = 16'h0aaa;
    errors = 0;
    num_checks = 0;
    repeat (20) @(negedge clk);
    chk(run_command_word_reg, 16'h0000, "cmd word reset");
    chk(speed_reference_word_reg, 16'h0000, "ref word reset");
    chk(ai2_is_current_reg, 16'h0001, "ai2 type reset");
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    key(0);
    chk(run_reg, 16'h0001, "keypad run");
    chk(reverse_reg, 16'h0000, "keypad forward");
    chk(target_ref_reg, 16'h01f4, "keypad ref");
    repeat (70000) @(negedge clk);
    chk(out_freq_reg == 16'h0001 || out_freq_reg == 16'h0002, 16'h0001, "ramp up");
    key(2);
    chk(reverse_reg, 16'h0001, "dir swap");
    reverse_inhibit = 1'b1;
    key(2);
    key(2);
    chk(reverse_reg, 16'h0000, "reverse refused");
    reverse_inhibit = 1'b0;
    key(1);
    chk(run_reg, 16'h0000, "keypad stop");
    chk(coast_stop_reg, 16'h0000, "decel stop");
    stop_mode = 1'b1;
    key(0);
    key(1);
    chk(coast_stop_reg, 16'h0001, "coast stop");
    chk(out_freq_reg, 16'h0000, "coast freq");
    stop_mode = 1'b0;
    $display("test keypad done");
    for (i = 1; i < 6; i = i + 1)
      if (i != 3)
      begin
        freq_source = i[2:0];
        repeat (3) @(negedge clk);
        chk(target_ref_reg, 16'h0111 * i[15:0], "ref source");
      end
    chk(aux_ref_reg, 16'h0aaa, "aux ref");
    chk(ai2_is_current_reg, 16'h0000, "ai2 type volts");
    input_type_switch = 1'b1;
    repeat (4) @(negedge clk);
    chk(ai2_is_current_reg, 16'h0001, "ai2 type current");
    for (i = 0; i < 4; i = i + 1)
    begin
      display_unit = i < 2 ? i[15:0] : i == 2 ? 16'h0004 : 16'h0028;
      repeat (4) @(negedge clk);
      chk(disp_fmt_reg, i[15:0], "display format");
    end
    run_source = 2'h1;
    term_fwd = 1'b1;
    repeat (10) @(negedge clk);
    chk(run_reg, 16'h0001, "terminal run");
    term_rev = 1'b1;
    repeat (10) @(negedge clk);
    chk({run_reg, reverse_reg}, 16'h0003, "terminal reverse");
    {term_fwd, term_rev} = 2'h0;
    run_source = 2'h3;
    plc_rev = 1'b1;
    repeat (10) @(negedge clk);
    chk({run_reg, reverse_reg}, 16'h0003, "plc reverse");
    plc_rev = 1'b0;
    $display("test sources done");
    freq_source = 3'h3;
    run_source = 2'h2;
    i_dcs_mb_master.send(48'h0106250203e8, 1'b0);
    chk(speed_reference_word_reg, 16'h03e8, "ref write");
    chk(target_ref_reg, 16'h03e8, "serial ref");
    i_dcs_mb_master.send(48'h010625029c41, 1'b0);
    chk(speed_reference_word_reg, 16'h03e8, "ref over limit");
    i_dcs_mb_master.send(48'h010625020bb8, 1'b1);
    chk(frame_err_reg, 16'h0001, "crc error");
    chk(speed_reference_word_reg, 16'h03e8, "bad frame ref");
    i_dcs_mb_master.send(48'h010625010003, 1'b0);
    chk(run_command_word_reg, 16'h0003, "cmd write");
    chk({run_reg, reverse_reg, frame_err_reg}, 16'h0006, "serial reverse");
    i_dcs_mb_master.send(48'h010625010000, 1'b0);
    chk(run_reg, 16'h0000, "serial stop");
    $display("test serial done");
    finish_test;
  end
endmodule
bind dcs_top dcs_props i_dcs_props (.clk, .rst_n, .freq_source, .run_source,
  .reverse_inhibit, .stop_mode, .display_unit, .keypad_ref, .run_reg, .reverse_reg,
  .coast_stop_reg, .out_freq_reg, .target_ref_reg, .disp_fmt_reg, .run_command_word_reg,
  .speed_reference_word_reg, .frame_err_reg);
